//--- include/vtp_regs.svh
// Purpose: offsets, field positions, reset values of the translation probe registers
// Assumes: byte addresses on a 32-bit register bus, one word per register
// Notes:   64-bit registers are split into a low and a high word
`ifndef VTP_REGS_SVH
`define VTP_REGS_SVH

`define VTP_OFF_CTRL      12'ha00
`define VTP_OFF_SID_LO    12'ha08
`define VTP_OFF_SID_HI    12'ha0c
`define VTP_OFF_ADDR_LO   12'ha10
`define VTP_OFF_ADDR_HI   12'ha14
`define VTP_OFF_RES_LO    12'ha18
`define VTP_OFF_RES_HI    12'ha1c

`define VTP_CTRL_RUN_BIT  0
`define VTP_CTRL_RST      32'h0000_0000

`define VTP_REQ_TYPE_HI   11
`define VTP_REQ_TYPE_LO   10
`define VTP_REQ_PRIV_BIT  9
`define VTP_REQ_DIR_BIT   8
`define VTP_REQ_INSTR_BIT 7
`define VTP_REQ_INHIB_BIT 6
`define VTP_REQ_WMASK     32'hffff_ffc0
`define VTP_REQ_STAGE1    2'b01

`define VTP_SHARE_OUTER   2'b10
`define VTP_CLASS_STAGE1  2'b00

`define VTP_RESP_OKAY     2'b00
`define VTP_RESP_DECERR   2'b11

`endif

//--- include/vtp_pkg.sv
// Purpose: types shared by the translation probe register block
// Assumes: walk engine sits outside and answers one request at a time
// Notes:   none
package vtp_pkg;

  typedef struct packed {
    logic [51:0] va;
    logic        priv;
    logic        read;
    logic        instr;
    logic        passive;
    logic [31:0] stream;
  } vtp_walk_req_t;

  typedef struct packed {
    logic        fault;
    logic [7:0]  mem_attrib;
    logic [39:0] oaddr;
    logic        size;
    logic [1:0]  share;
    logic [7:0]  fcode;
    logic [3:0]  impl_data;
  } vtp_walk_rsp_t;

  typedef enum logic [2:0] {
    VTP_IDLE = 3'b001,
    VTP_WALK = 3'b010,
    VTP_DONE = 3'b100
  } vtp_state_t;

endpackage

//--- core/vtp_probe.sv
// Purpose: software register bank that runs one stage 1 address translation probe
// Assumes: AXI4-Lite slave, 32-bit data; walk engine answers with a one-cycle ack
// Notes:   control register is the secure copy; non-secure access to it is RAZ/WI
`include "vtp_regs.svh"

module vtp_probe #(
  parameter int          ADDR_W      = 12,
  parameter bit          WIDE_OADDR  = 1'b1,
  parameter logic [7:0]  BAD_REQ_CODE = 8'h01
) (
  input  wire logic                  CLK,
  input  wire logic                  ARST_N,
  input  wire logic [ADDR_W-1:0]     AWADDR,
  input  wire logic [2:0]            AWPROT,
  input  wire logic                  AWVALID,
  output      logic                  AWREADY,
  input  wire logic [31:0]           WDATA,
  input  wire logic [3:0]            WSTRB,
  input  wire logic                  WVALID,
  output      logic                  WREADY,
  output      logic [1:0]            BRESP,
  output      logic                  BVALID,
  input  wire logic                  BREADY,
  input  wire logic [ADDR_W-1:0]     ARADDR,
  input  wire logic [2:0]            ARPROT,
  input  wire logic                  ARVALID,
  output      logic                  ARREADY,
  output      logic [31:0]           RDATA,
  output      logic [1:0]            RRESP,
  output      logic                  RVALID,
  input  wire logic                  RREADY,
  output      logic                  WALK_VALID,
  output      vtp_pkg::vtp_walk_req_t WALK_REQ,
  input  wire logic                  WALK_DONE,
  input  wire vtp_pkg::vtp_walk_rsp_t WALK_RSP,
  output      logic                  PROBE_BUSY
);
  import vtp_pkg::*;

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    return (a == `VTP_OFF_CTRL)    || (a == `VTP_OFF_SID_LO) ||
           (a == `VTP_OFF_SID_HI)  || (a == `VTP_OFF_ADDR_LO) ||
           (a == `VTP_OFF_ADDR_HI) || (a == `VTP_OFF_RES_LO) ||
           (a == `VTP_OFF_RES_HI);
  endfunction

  // write and read channel holding registers
  logic              aw_full_r;
  logic [11:0]       aw_addr_r;
  logic              aw_sec_r;
  logic              w_full_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  // register state
  vtp_state_t        state_r;
  vtp_state_t        state_nxt;
  logic [31:0]       req_lo_r;
  logic [31:0]       req_hi_r;
  logic [31:0]       sid_lo_r;
  logic [31:0]       sid_hi_r;
  logic [63:0]       res_r;
  vtp_walk_req_t     cap_r;
  logic              cap_bad_r;

  // decode
  logic              do_wr;
  logic              run;
  logic              wr_ctrl;
  logic              wr_req_lo;
  logic              wr_req_hi;
  logic              wr_sid_lo;
  logic              wr_sid_hi;
  logic              start;
  logic [11:0]       rd_addr;
  logic              rd_sec;
  logic [31:0]       rd_mux;
  logic              rd_ok;
  logic              wr_ok;
  logic [1:0]        req_type;
  logic              req_read;
  logic              eff_instr;
  logic              dev_mem;
  logic [1:0]        eff_share;
  logic [39:0]       eff_oaddr;
  logic [63:0]       ok_word;
  logic [63:0]       fault_word;

  assign rd_addr  = 12'(ARADDR);
  assign rd_sec   = ~ARPROT[1];
  assign run      = (state_r != VTP_IDLE);
  assign do_wr    = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_ok    = is_mapped(aw_addr_r);
  assign rd_ok    = is_mapped(rd_addr);

  // secure-only control; the run bit holds off a second start
  assign wr_ctrl   = do_wr & (aw_addr_r == `VTP_OFF_CTRL) & aw_sec_r;
  assign start     = wr_ctrl & w_strb_r[0] & w_data_r[`VTP_CTRL_RUN_BIT] & ~run;
  assign wr_req_lo = do_wr & (aw_addr_r == `VTP_OFF_ADDR_LO) & ~run;
  assign wr_req_hi = do_wr & (aw_addr_r == `VTP_OFF_ADDR_HI) & ~run;
  assign wr_sid_lo = do_wr & (aw_addr_r == `VTP_OFF_SID_LO) & ~run;
  assign wr_sid_hi = do_wr & (aw_addr_r == `VTP_OFF_SID_HI) & ~run;

  // request field decode at the moment of capture
  assign req_type  = req_lo_r[`VTP_REQ_TYPE_HI:`VTP_REQ_TYPE_LO];
  assign req_read  = req_lo_r[`VTP_REQ_DIR_BIT];
  // a write probe is always a data access
  assign eff_instr = req_read & req_lo_r[`VTP_REQ_INSTR_BIT];

  // result words
  // device memory types have a zero upper nibble in the attribute byte
  assign dev_mem   = (WALK_RSP.mem_attrib[7:4] == 4'h0);
  assign eff_share = dev_mem ? `VTP_SHARE_OUTER : WALK_RSP.share;
  assign eff_oaddr = WIDE_OADDR ? WALK_RSP.oaddr
                                : {4'h0, WALK_RSP.oaddr[35:0]};
  assign ok_word = {WALK_RSP.mem_attrib,
                    4'h0,
                    eff_oaddr,
                    WALK_RSP.size,
                    1'b0,
                    eff_share,
                    7'h00,
                    1'b0};
  assign fault_word = {WALK_RSP.impl_data,
                       8'h00,
                       40'h0,
                       WALK_RSP.fcode,
                       1'b0,
                       `VTP_CLASS_STAGE1,
                       1'b1};

  // read mux; non-secure view of the control word is zero
  assign rd_mux =
    (rd_addr == `VTP_OFF_CTRL)    ? (rd_sec ? {31'h0, run} : 32'h0) :
    (rd_addr == `VTP_OFF_SID_LO)  ? sid_lo_r :
    (rd_addr == `VTP_OFF_SID_HI)  ? sid_hi_r :
    (rd_addr == `VTP_OFF_ADDR_LO) ? req_lo_r :
    (rd_addr == `VTP_OFF_ADDR_HI) ? req_hi_r :
    (rd_addr == `VTP_OFF_RES_LO)  ? res_r[31:0] :
    (rd_addr == `VTP_OFF_RES_HI)  ? res_r[63:32] : 32'h0;

  // handshakes
  assign AWREADY    = ~aw_full_r;
  assign WREADY     = ~w_full_r;
  assign BVALID     = bvalid_r;
  assign BRESP      = bresp_r;
  assign ARREADY    = ~rvalid_r;
  assign RVALID     = rvalid_r;
  assign RDATA      = rdata_r;
  assign RRESP      = rresp_r;
  assign WALK_VALID = (state_r == VTP_WALK);
  assign WALK_REQ   = cap_r;
  assign PROBE_BUSY = run;

  // address and data are taken in either order
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 12'h000;
      aw_sec_r  <= 1'b0;
    end else if (AWVALID && !aw_full_r) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= 12'(AWADDR);
      aw_sec_r  <= ~AWPROT[1];
    end else if (do_wr) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      w_full_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else if (WVALID && !w_full_r) begin
      w_full_r <= 1'b1;
      w_data_r <= WDATA;
      w_strb_r <= WSTRB;
    end else if (do_wr) begin
      w_full_r <= 1'b0;
    end
  end

  // writes to read-only or guarded words still answer okay
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `VTP_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? `VTP_RESP_OKAY : `VTP_RESP_DECERR;
    end else if (BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= `VTP_RESP_OKAY;
    end else if (ARVALID && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_ok ? rd_mux : 32'h0;
      rresp_r  <= rd_ok ? `VTP_RESP_OKAY : `VTP_RESP_DECERR;
    end else if (RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // request and stream words; frozen while a probe runs
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      req_lo_r <= 32'h0;
      req_hi_r <= 32'h0;
      sid_lo_r <= 32'h0;
      sid_hi_r <= 32'h0;
    end else begin
      if (wr_req_lo) begin
        req_lo_r <= merge_bytes(req_lo_r, w_data_r, w_strb_r) & `VTP_REQ_WMASK;
      end
      if (wr_req_hi) begin
        req_hi_r <= merge_bytes(req_hi_r, w_data_r, w_strb_r);
      end
      if (wr_sid_lo) begin
        sid_lo_r <= merge_bytes(sid_lo_r, w_data_r, w_strb_r);
      end
      if (wr_sid_hi) begin
        sid_hi_r <= merge_bytes(sid_hi_r, w_data_r, w_strb_r);
      end
    end
  end

  // snapshot at start so the walk never sees later register edits
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cap_r     <= '0;
      cap_bad_r <= 1'b0;
    end else if (start) begin
      cap_r.va      <= {req_hi_r, req_lo_r[31:12]};
      cap_r.priv    <= req_lo_r[`VTP_REQ_PRIV_BIT];
      cap_r.read    <= req_read;
      cap_r.instr   <= eff_instr;
      cap_r.passive <= req_lo_r[`VTP_REQ_INHIB_BIT];
      cap_r.stream  <= sid_lo_r;
      cap_bad_r     <= (req_type != `VTP_REQ_STAGE1);
    end
  end

  // probe sequencing; a written zero to run is dropped, never cancels
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      VTP_IDLE: begin
        if (start) begin
          state_nxt = VTP_WALK;
        end
      end
      VTP_WALK: begin
        if (cap_bad_r || WALK_DONE) begin
          state_nxt = VTP_DONE;
        end
      end
      VTP_DONE: begin
        state_nxt = VTP_IDLE;
      end
      default: begin
        state_nxt = VTP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= VTP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // result lands one cycle before run reads clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      res_r <= 64'h0;
    end else if (state_r == VTP_WALK) begin
      if (cap_bad_r) begin
        res_r <= {4'h0, 8'h00, 40'h0, BAD_REQ_CODE, 1'b0,
                  `VTP_CLASS_STAGE1, 1'b1};
      end else if (WALK_DONE) begin
        res_r <= WALK_RSP.fault ? fault_word : ok_word;
      end
    end
  end

endmodule

//--- test/vtp_probe_props.sv
// Purpose: port-level checks of the translation probe register block
// Assumes: single clock domain, reset asynchronous and active low
// Notes:   bound into every vtp_probe instance
module vtp_props #(
  parameter int ADDR_W = 12
) (
  input wire logic                   CLK,
  input wire logic                   ARST_N,
  input wire logic [ADDR_W-1:0]      ARADDR,
  input wire logic [2:0]             ARPROT,
  input wire logic                   ARVALID,
  input wire logic                   ARREADY,
  input wire logic [31:0]            RDATA,
  input wire logic                   RVALID,
  input wire logic                   WALK_VALID,
  input wire vtp_pkg::vtp_walk_req_t WALK_REQ,
  input wire logic                   WALK_DONE,
  input wire logic                   PROBE_BUSY
);
  import vtp_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  sequence s_finish;
    !WALK_VALID && PROBE_BUSY ##1 !PROBE_BUSY;
  endsequence
  sequence s_ctrl_rd;
    ARVALID && ARREADY && ARADDR == 12'ha00;
  endsequence
  property p_finish;
    WALK_VALID && WALK_DONE |=> s_finish;
  endproperty
  a_finish: assert property (p_finish) else $error("run not cleared after walk");
  property p_start;
    $rose(PROBE_BUSY) |-> WALK_VALID;
  endproperty
  a_start: assert property (p_start) else $error("walk not started with run");
  property p_req_hold;
    WALK_VALID && !WALK_DONE |=> $stable(WALK_REQ);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("walk request moved");
  property p_no_cancel;
    WALK_VALID && !WALK_DONE |=> PROBE_BUSY;
  endproperty
  a_no_cancel: assert property (p_no_cancel) else $error("run dropped early");
  property p_walk_busy;
    WALK_VALID |-> PROBE_BUSY;
  endproperty
  a_walk_busy: assert property (p_walk_busy) else $error("walk while idle");
  property p_wr_data;
    WALK_VALID && !WALK_REQ.read |-> !WALK_REQ.instr;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write sent as instruction");
  property p_ctrl_rsvd;
    s_ctrl_rd |=> RVALID && RDATA[31:1] == 31'h0;
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved bits set");
  property p_nonsec;
    ARVALID && ARREADY && ARADDR == 12'ha00 && ARPROT[1] |=> RDATA == 32'h0;
  endproperty
  a_nonsec: assert property (p_nonsec) else $error("non-secure control read not zero");
endmodule

bind vtp_probe vtp_props #(.ADDR_W(ADDR_W)) u_props (.*);

//--- test/tb_virtual_translation_probe_regs.sv
// Purpose: self-checking bench for the translation probe register block
// Assumes: bench plays both software master and walk engine
// Notes:   ready inputs held high, which the bus allows
module tb_virtual_translation_probe_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import vtp_pkg::*;
  logic CLK = 1'b0, ARST_N = 1'b1, AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0;
  logic BREADY = 1'b1, RREADY = 1'b1, WALK_DONE = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, WALK_VALID, PROBE_BUSY;
  logic [11:0] AWADDR = 12'h0, ARADDR = 12'h0;
  logic [2:0] AWPROT = 3'h0, ARPROT = 3'h0;
  logic [31:0] WDATA = 32'h0, RDATA, rdat;
  logic [3:0] WSTRB = 4'hf;
  logic [1:0] BRESP, RRESP, rrsp;
  vtp_walk_req_t WALK_REQ;
  vtp_walk_rsp_t WALK_RSP = '0;
  int fails = 0, check_count = 0;

  vtp_probe dut (.*);

  always #2.5 CLK = ~CLK;

  task wrap_up;
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [63:0] s, input logic [63:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [2:0] p);
    AWADDR <= a;
    AWPROT <= p;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    rrsp = BRESP;
  endtask

  task rd(input logic [11:0] a, input logic [2:0] p);
    ARADDR <= a;
    ARPROT <= p;
    ARVALID <= 1'b1;
    do @(posedge CLK); while (!ARREADY);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (!RVALID);
    rdat = RDATA;
    rrsp = RRESP;
  endtask

  // engine answers once, then releases its data lines to the inverse
  task walk(input vtp_walk_rsp_t r);
    while (!WALK_VALID) @(posedge CLK);
    WALK_RSP <= r;
    WALK_DONE <= 1'b1;
    @(posedge CLK);
    WALK_DONE <= 1'b0;
    WALK_RSP <= ~r;
    while (PROBE_BUSY) @(posedge CLK);
  endtask

  task t_misc;
    rd(12'ha00, 3'b000);
    chk(rdat, 32'h0);
    wr(12'ha00, 32'h1, 3'b010);
    chk(PROBE_BUSY, 1'b0);
    rd(12'h100, 3'b000);
    chk({rrsp, rdat}, {2'b11, 32'h0});
    wr(12'h100, 32'h1, 3'b000);
    chk(rrsp, 2'b11);
    wr(12'ha08, 32'h0, 3'b000);
    chk(rrsp, 2'b00);
  endtask

  task t_ok(input logic [7:0] mattr, input logic [1:0] shr, input logic [1:0] shr_x);
    wr(12'ha08, 32'h55, 3'b000);
    wr(12'ha10, 32'habcde7ff, 3'b000);
    wr(12'ha14, 32'h00123456, 3'b000);
    wr(12'ha00, 32'h1, 3'b000);
    chk({WALK_REQ.va, WALK_REQ.priv, WALK_REQ.read, WALK_REQ.instr, WALK_REQ.passive},
        64'h0000_1234_56ab_cdef);
    chk(WALK_REQ.stream, 32'h55);
    wr(12'ha10, 32'h0, 3'b000);
    wr(12'ha00, 32'h0, 3'b000);
    rd(12'ha10, 3'b000);
    chk(rdat, 32'habcde7c0);
    rd(12'ha00, 3'b000);
    chk(rdat, 32'h1);
    rd(12'ha00, 3'b010);
    chk(rdat, 32'h0);
    walk({1'b0, mattr, 40'hf_0123_4567, shr[0], shr, 8'h0, 4'h0});
    rd(12'ha18, 3'b000);
    chk(rdat, {20'h34567, shr[0], 1'b0, shr_x, 8'h00});
    rd(12'ha1c, 3'b000);
    chk(rdat, {mattr, 4'h0, 20'h0f012});
  endtask

  task t_fault;
    wr(12'ha10, 32'h12345480, 3'b000);
    wr(12'ha14, 32'h0, 3'b000);
    wr(12'ha00, 32'h1, 3'b000);
    chk({WALK_REQ.priv, WALK_REQ.read, WALK_REQ.instr, WALK_REQ.passive}, 4'h0);
    walk({1'b1, 8'hff, 40'hff_ffff_ffff, 1'b1, 2'b11, 8'h2a, 4'h9});
    wr(12'ha18, 32'hffffffff, 3'b000);
    rd(12'ha18, 3'b000);
    chk(rdat, 32'h0000_02a1);
    rd(12'ha1c, 3'b000);
    chk(rdat, 32'h9000_0000);
  endtask

  task t_bad;
    for (int t = 0; t < 4; t++) begin
      if (t != 1) begin
        wr(12'ha10, {20'h1, t[1:0], 10'h0}, 3'b000);
        wr(12'ha00, 32'h1, 3'b000);
        while (PROBE_BUSY) @(posedge CLK);
        rd(12'ha18, 3'b000);
        chk(rdat, 32'h0000_0011);
      end
    end
  endtask

  initial begin
    ARST_N <= 1'b0;
    repeat (5) @(posedge CLK);
    ARST_N <= 1'b1;
    @(posedge CLK);
    t_misc;
    t_ok(8'hff, 2'b11, 2'b11);
    t_ok(8'h04, 2'b11, 2'b10);
    t_ok(8'h44, 2'b00, 2'b00);
    t_fault;
    t_bad;
    wrap_up;
  end

  initial begin
    #20000;
    fails++;
    wrap_up;
  end
endmodule
